// [hw/pwm3_consts.svh]
// Constants for the dual PWM shared-period timer
`ifndef PWM3_CONSTS_SVH
`define PWM3_CONSTS_SVH
`define CNT_W 16
`define CNT_ZERO 16'h0000
`define CNT_ONE 16'h0001
`define CNT_MAX 16'hffff
`define SRC_W 3
`define SRC_F1 3'h0
`define SRC_F2 3'h1
`define SRC_F4 3'h2
`define SRC_F8 3'h3
`define SRC_F32 3'h4
`define SRC_FOSC 3'h5
`define DIV_W 5
`define DIV_ZERO 5'h00
`define DIV_ONE 5'h01
`define GSEL_W 3
`define GREG_A0 3'h0
`define GREG_A1 3'h1
`define GREG_B0 3'h2
`define GREG_B1 3'h3
`define GREG_C0 3'h4
`define GREG_C1 3'h5
`define GREG_D0 3'h6
`define GREG_D1 3'h7
`define NGREG 8
`define NFLAG 5
`define FLG_MA0 0
`define FLG_MA1 1
`define FLG_MB0 2
`define FLG_MB1 3
`define FLG_OVF 4
`define FLAGS_ZERO 5'h00
`define STRT_W 4
`define STRT_RUN0 0
`define STRT_RUN1 1
`define STRT_SEL0 2
`define STRT_SEL1 3
`define BUF_W 4
`define BUF_C0 0
`define BUF_C1 1
`define BUF_D0 2
`define BUF_D1 3
`define INIT_A 0
`define INIT_B 1
`define INIT_RST 2'h0
`endif

// [hw/pwm3_pkg.sv]
// Types shared by the dual PWM shared-period timer
`include "pwm3_consts.svh"
package pwm3_pkg;
    typedef logic [`CNT_W-1:0] count_t;
    typedef logic [`NFLAG-1:0] flags_t;
    typedef logic [`SRC_W-1:0] src_sel_t;
endpackage

// [hw/count_tick_gen.sv]
// Count clock selection and prescaler producing a one-cycle count tick
`timescale 1ns/1ps
`include "pwm3_consts.svh"
module count_tick_gen
    import pwm3_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    input wire logic clk_en_i,
    input wire src_sel_t clk_sel_i,
    input wire logic fast_osc_clock_i,
    output logic tick_o
);
    logic osc_meta_ff, osc_sync_ff, osc_prev_ff;
    logic [`DIV_W-1:0] div_ff;
    logic tick_ff;
    logic nxt_osc_meta, nxt_osc_sync, nxt_osc_prev, nxt_tick;
    logic [`DIV_W-1:0] nxt_div;

    function automatic logic src_tick(input src_sel_t sel, input logic [`DIV_W-1:0] div,
                                      input logic osc_rise);
        case (sel)
            `SRC_F1: src_tick = 1'b1;
            `SRC_F2: src_tick = div[0];
            `SRC_F4: src_tick = &div[1:0];
            `SRC_F8: src_tick = &div[2:0];
            `SRC_F32: src_tick = &div;
            `SRC_FOSC: src_tick = osc_rise;
            default: src_tick = 1'b0;
        endcase
    endfunction

    always_comb begin
        nxt_osc_meta = fast_osc_clock_i;
        nxt_osc_sync = osc_meta_ff;
        nxt_osc_prev = osc_sync_ff;
        nxt_div = div_ff + `DIV_ONE;
        // Oscillator edges sampled on the system clock, so it must run slower than half of it
        nxt_tick = src_tick(clk_sel_i, div_ff, osc_sync_ff & ~osc_prev_ff);
    end

    always_ff @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            osc_meta_ff <= 1'b0;
            osc_sync_ff <= 1'b0;
            osc_prev_ff <= 1'b0;
            div_ff <= `DIV_ZERO;
            tick_ff <= 1'b0;
        end else if (clk_en_i) begin
            osc_meta_ff <= nxt_osc_meta;
            osc_sync_ff <= nxt_osc_sync;
            osc_prev_ff <= nxt_osc_prev;
            div_ff <= nxt_div;
            tick_ff <= nxt_tick;
        end
    end

    assign tick_o = tick_ff;
endmodule

// [hw/dual_pwm_shared_period.sv]
// Dual PWM shared-period timer: counter, compares, outputs, status
//
// Overview of operation
// - Two PWM outputs share one period register
// - Count clock from divided or oscillator sources
// - Only main counter counts; second counter unused
// - Period lasts period value plus one ticks
// - Output A active from n to m
// - Output B active from q to p
// - Writing run bit 1 starts counting
// - Software stop holds outputs at current levels
// - Auto stop clears run bit on period match
// - Channel 1 run bit cleared by its match
// - Compare matches and overflow raise request flags
// - Channel 0 A and B pins drive PWM
// - External pin can force pulse outputs off
// - Main counter readable and loadable
// - Per-pin active level, optional buffered compares
// - A uses the period and one compare, B uses two
// - Initial level driven when initial register written
// - Flags clear by write zero after read one
`timescale 1ns/1ps
`include "pwm3_consts.svh"
module dual_pwm_shared_period
    import pwm3_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    input wire logic clk_en_i,
    input wire src_sel_t clk_sel_i,
    input wire logic fast_osc_clock_i,
    input wire logic start_ctrl_wr_i,
    input wire logic [`STRT_W-1:0] start_ctrl_wdata_i,
    input wire logic counter_wr_i,
    input wire count_t counter_wdata_i,
    input wire logic greg_wr_i,
    input wire logic [`GSEL_W-1:0] greg_sel_i,
    input wire count_t greg_wdata_i,
    input wire logic [`BUF_W-1:0] buf_en_i,
    input wire logic init_level_wr_i,
    input wire logic [1:0] init_level_wdata_i,
    input wire logic status_rd_i,
    input wire logic status_wr_i,
    input wire flags_t status_wdata_i,
    input wire logic cutoff_en_i,
    input wire logic ext_irq_pin_i,
    output logic run_bit_ch0_o,
    output logic run_bit_ch1_o,
    output logic stop_select_ch0_o,
    output logic stop_select_ch1_o,
    output count_t main_counter_o,
    output flags_t status_o,
    output logic ext_irq_sync_o,
    output logic pwm_out_a_o,
    output logic pwm_out_a_oe_n_o,
    output logic pwm_out_b_o,
    output logic pwm_out_b_oe_n_o
);
    logic tick;
    count_t cnt_ff, nxt_cnt;
    count_t greg_ff [`NGREG];
    count_t nxt_greg [`NGREG];
    logic run0_ff, run1_ff, sel0_ff, sel1_ff;
    logic nxt_run0, nxt_run1, nxt_sel0, nxt_sel1;
    logic [1:0] init_ff, nxt_init;
    logic lvl_a_ff, lvl_b_ff, nxt_lvl_a, nxt_lvl_b;
    flags_t flags_ff, nxt_flags, arm_ff, nxt_arm, set_flags, clr_flags;
    logic irq_meta_ff, irq_sync_ff, cut_ff, nxt_cut;
    logic counting, m_a0, m_a1, m_b0, m_b1, ovf;

    count_tick_gen u_tick (
        .sys_clk_i(sys_clk_i),
        .reset_n_i(reset_n_i),
        .clk_en_i(clk_en_i),
        .clk_sel_i(clk_sel_i),
        .fast_osc_clock_i(fast_osc_clock_i),
        .tick_o(tick)
    );

    // Compares sample the counter only on a count tick while running
    always_comb begin
        counting = tick & run0_ff;
        m_a0 = counting & (cnt_ff == greg_ff[`GREG_A0]);
        m_a1 = counting & (cnt_ff == greg_ff[`GREG_A1]);
        m_b0 = counting & (cnt_ff == greg_ff[`GREG_B0]);
        m_b1 = counting & (cnt_ff == greg_ff[`GREG_B1]);
        ovf = counting & (cnt_ff == `CNT_MAX) & ~m_a0;
    end

    // Counter
    always_comb begin
        nxt_cnt = cnt_ff;
        if (counter_wr_i) begin
            nxt_cnt = counter_wdata_i;
        end else if (m_a0) begin
            nxt_cnt = `CNT_ZERO;
        end else if (counting) begin
            nxt_cnt = cnt_ff + `CNT_ONE;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            cnt_ff <= `CNT_ZERO;
        end else if (clk_en_i) begin
            cnt_ff <= nxt_cnt;
        end
    end

    // General registers; buffers load their partners at the period match
    always_comb begin
        for (int i = 0; i < `NGREG; i++) begin
            nxt_greg[i] = greg_ff[i];
        end
        if (m_a0) begin
            if (buf_en_i[`BUF_C0]) nxt_greg[`GREG_A0] = greg_ff[`GREG_C0];
            if (buf_en_i[`BUF_C1]) nxt_greg[`GREG_A1] = greg_ff[`GREG_C1];
            if (buf_en_i[`BUF_D0]) nxt_greg[`GREG_B0] = greg_ff[`GREG_D0];
            if (buf_en_i[`BUF_D1]) nxt_greg[`GREG_B1] = greg_ff[`GREG_D1];
        end
        if (greg_wr_i) begin
            nxt_greg[greg_sel_i] = greg_wdata_i;
        end
    end

    generate
        for (genvar g = 0; g < `NGREG; g++) begin : gen_greg
            always_ff @(posedge sys_clk_i) begin
                if (!reset_n_i) begin
                    greg_ff[g] <= `CNT_MAX;
                end else if (clk_en_i) begin
                    greg_ff[g] <= nxt_greg[g];
                end
            end
        end
    endgenerate

    // Start control; a software write beats a same-cycle automatic stop
    always_comb begin
        nxt_run0 = run0_ff;
        nxt_run1 = run1_ff;
        nxt_sel0 = sel0_ff;
        nxt_sel1 = sel1_ff;
        if (start_ctrl_wr_i) begin
            nxt_run0 = start_ctrl_wdata_i[`STRT_RUN0];
            nxt_run1 = start_ctrl_wdata_i[`STRT_RUN1];
            nxt_sel0 = start_ctrl_wdata_i[`STRT_SEL0];
            nxt_sel1 = start_ctrl_wdata_i[`STRT_SEL1];
        end else begin
            if (m_a0 && !sel0_ff) nxt_run0 = 1'b0;
            if (m_a1 && !sel1_ff) nxt_run1 = 1'b0;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            run0_ff <= 1'b0;
            run1_ff <= 1'b0;
            sel0_ff <= 1'b0;
            sel1_ff <= 1'b0;
        end else if (clk_en_i) begin
            run0_ff <= nxt_run0;
            run1_ff <= nxt_run1;
            sel0_ff <= nxt_sel0;
            sel1_ff <= nxt_sel1;
        end
    end

    // Output levels; the initial level is the inactive one, its inverse active
    always_comb begin
        nxt_init = init_ff;
        nxt_lvl_a = lvl_a_ff;
        nxt_lvl_b = lvl_b_ff;
        if (init_level_wr_i) begin
            nxt_init = init_level_wdata_i;
            nxt_lvl_a = init_level_wdata_i[`INIT_A];
            nxt_lvl_b = init_level_wdata_i[`INIT_B];
        end else begin
            // Return wins over activate when both compares hit together
            if (m_a0) nxt_lvl_a = init_ff[`INIT_A];
            else if (m_a1) nxt_lvl_a = ~init_ff[`INIT_A];
            if (m_b0) nxt_lvl_b = init_ff[`INIT_B];
            else if (m_b1) nxt_lvl_b = ~init_ff[`INIT_B];
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            init_ff <= `INIT_RST;
            lvl_a_ff <= 1'b0;
            lvl_b_ff <= 1'b0;
        end else if (clk_en_i) begin
            init_ff <= nxt_init;
            lvl_a_ff <= nxt_lvl_a;
            lvl_b_ff <= nxt_lvl_b;
        end
    end

    // Status flags; a hardware set beats a clear in the same cycle
    always_comb begin
        set_flags = `FLAGS_ZERO;
        set_flags[`FLG_MA0] = m_a0;
        set_flags[`FLG_MA1] = m_a1;
        set_flags[`FLG_MB0] = m_b0;
        set_flags[`FLG_MB1] = m_b1;
        set_flags[`FLG_OVF] = ovf;
        clr_flags = status_wr_i ? (arm_ff & ~status_wdata_i) : `FLAGS_ZERO;
        nxt_flags = set_flags | (flags_ff & ~clr_flags);
        nxt_arm = arm_ff;
        if (status_wr_i) nxt_arm = `FLAGS_ZERO;
        else if (status_rd_i) nxt_arm = flags_ff;
    end

    always_ff @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            flags_ff <= `FLAGS_ZERO;
            arm_ff <= `FLAGS_ZERO;
        end else if (clk_en_i) begin
            flags_ff <= nxt_flags;
            arm_ff <= nxt_arm;
        end
    end

    // External pin sync and forced cutoff on a low pin level
    always_comb begin
        nxt_cut = cutoff_en_i & ~irq_sync_ff;
    end

    always_ff @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            irq_meta_ff <= 1'b1;
            irq_sync_ff <= 1'b1;
            cut_ff <= 1'b0;
        end else if (clk_en_i) begin
            irq_meta_ff <= ext_irq_pin_i;
            irq_sync_ff <= irq_meta_ff;
            cut_ff <= nxt_cut;
        end
    end

    assign run_bit_ch0_o = run0_ff;
    assign run_bit_ch1_o = run1_ff;
    assign stop_select_ch0_o = sel0_ff;
    assign stop_select_ch1_o = sel1_ff;
    assign main_counter_o = cnt_ff;
    assign status_o = flags_ff;
    assign ext_irq_sync_o = irq_sync_ff;
    assign pwm_out_a_o = lvl_a_ff;
    assign pwm_out_b_o = lvl_b_ff;
    assign pwm_out_a_oe_n_o = cut_ff;
    assign pwm_out_b_oe_n_o = cut_ff;

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!reset_n_i);

    sequence s_period_hit;
        clk_en_i && m_a0 && !counter_wr_i;
    endsequence

    sequence s_plain_step;
        clk_en_i && counting && !m_a0 && !counter_wr_i;
    endsequence

    period_wrap_a: assert property (s_period_hit |=> cnt_ff == `CNT_ZERO)
        else $error("counter did not wrap at period match");
    count_step_a: assert property (s_plain_step |=> cnt_ff == $past(cnt_ff) + `CNT_ONE)
        else $error("counter did not advance by one");
    auto_stop_a: assert property (s_period_hit ##0 (!sel0_ff && !start_ctrl_wr_i)
        |=> !run0_ff)
        else $error("run bit not cleared by period match");
    start_run_a: assert property (clk_en_i && start_ctrl_wr_i
        && start_ctrl_wdata_i[`STRT_RUN0] |=> run0_ff)
        else $error("run bit not set by write");
    stopped_hold_a: assert property (!run0_ff && !init_level_wr_i
        |=> $stable(lvl_a_ff) && $stable(lvl_b_ff))
        else $error("output changed while stopped");
    out_a_edges_a: assert property (clk_en_i && m_a1 && !m_a0 && !init_level_wr_i
        |=> pwm_out_a_o != init_ff[`INIT_A])
        else $error("output A not active at its compare");
    out_b_return_a: assert property (clk_en_i && m_b0 && !init_level_wr_i
        |=> pwm_out_b_o == init_ff[`INIT_B])
        else $error("output B not returned at its compare");
    out_b_active_a: assert property (clk_en_i && m_b1 && !m_b0 && !init_level_wr_i
        |=> pwm_out_b_o != init_ff[`INIT_B])
        else $error("output B not active at its compare");
    ch1_stop_a: assert property (clk_en_i && m_a1 && !sel1_ff && !start_ctrl_wr_i
        |=> !run1_ff)
        else $error("channel 1 run bit not cleared");
    flag_set_a: assert property (clk_en_i && ovf |=> flags_ff[`FLG_OVF])
        else $error("overflow flag not set");
    flag_keep_a: assert property (clk_en_i && status_wr_i && !status_rd_i
        && (status_wdata_i == ~`FLAGS_ZERO)
        |=> (flags_ff & $past(flags_ff)) == $past(flags_ff))
        else $error("flag cleared by writing one");
    counter_load_a: assert property (clk_en_i && counter_wr_i
        |=> cnt_ff == $past(counter_wdata_i))
        else $error("counter write not loaded");
    init_drive_a: assert property (clk_en_i && init_level_wr_i
        |=> pwm_out_a_o == $past(init_level_wdata_i[`INIT_A]))
        else $error("initial level not driven");
    cutoff_drive_a: assert property (clk_en_i && cutoff_en_i && !irq_sync_ff
        |=> pwm_out_a_oe_n_o && pwm_out_b_oe_n_o)
        else $error("outputs not cut off by pin");
endmodule

// [sim/pwm_load_model.sv]
// Load model on one PWM pin measuring active width and period in clock cycles
`timescale 1ns/1ps
module pwm_load_model (
    input wire logic sys_clk_i,
    input wire logic pin_i,
    input wire logic oe_n_i,
    input wire logic act_high_i,
    output int width_o,
    output int period_o
);
    int now = 0;
    int t_rise = 0;
    logic act_ff = 1'b0;
    logic act;
    // A cut-off pin floats, so the load sees no active level
    assign act = (oe_n_i === 1'b0) && (pin_i === act_high_i);
    always @(posedge sys_clk_i) begin
        now <= now + 1;
        act_ff <= act;
        if (act && !act_ff) begin
            period_o <= now - t_rise;
            t_rise <= now;
        end
        if (!act && act_ff) begin
            width_o <= now - t_rise;
        end
    end
endmodule

// [sim/test_dual_pwm_shared_period.sv]
// Self-checking bench for the dual PWM shared-period timer
`timescale 1ns/1ps
`include "pwm3_consts.svh"
module test_dual_pwm_shared_period;
    import pwm3_pkg::*;
    logic sys_clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic clk_en_i = 1'b1;
    src_sel_t clk_sel_i = `SRC_F1;
    logic fast_osc_clock_i = 1'b0;
    logic start_ctrl_wr_i = 1'b0;
    logic [`STRT_W-1:0] start_ctrl_wdata_i = 4'h0;
    logic counter_wr_i = 1'b0;
    count_t counter_wdata_i = `CNT_ZERO;
    logic greg_wr_i = 1'b0;
    logic [`GSEL_W-1:0] greg_sel_i = `GREG_A0;
    count_t greg_wdata_i = `CNT_ZERO;
    logic [`BUF_W-1:0] buf_en_i = 4'h0;
    logic init_level_wr_i = 1'b0;
    logic [1:0] init_level_wdata_i = 2'h0;
    logic status_rd_i = 1'b0;
    logic status_wr_i = 1'b0;
    flags_t status_wdata_i = `FLAGS_ZERO;
    logic cutoff_en_i = 1'b0;
    logic ext_irq_pin_i = 1'b1;
    logic run0, run1, sel0, sel1, irq_sync, pa, pa_oe_n, pb, pb_oe_n;
    count_t cnt;
    flags_t stat;
    logic act_a = 1'b1;
    logic act_b = 1'b1;
    int wa, pera, wb, perb;
    int bad_count = 0;
    int check_count = 0;
    int divs[$] = '{1, 2, 4, 8, 32, 5};
    int m, n, p, q, k;
    logic pa_h, pb_h;
    count_t c_h;

    always #2 sys_clk_i = ~sys_clk_i;
    // Oscillator at a fifth of the system rate, phase unrelated
    initial begin
        #1.3;
        forever #10 fast_osc_clock_i = ~fast_osc_clock_i;
    end

    dual_pwm_shared_period uut (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
        .clk_en_i(clk_en_i), .clk_sel_i(clk_sel_i), .fast_osc_clock_i(fast_osc_clock_i),
        .start_ctrl_wr_i(start_ctrl_wr_i), .start_ctrl_wdata_i(start_ctrl_wdata_i),
        .counter_wr_i(counter_wr_i), .counter_wdata_i(counter_wdata_i),
        .greg_wr_i(greg_wr_i), .greg_sel_i(greg_sel_i), .greg_wdata_i(greg_wdata_i),
        .buf_en_i(buf_en_i), .init_level_wr_i(init_level_wr_i),
        .init_level_wdata_i(init_level_wdata_i), .status_rd_i(status_rd_i),
        .status_wr_i(status_wr_i), .status_wdata_i(status_wdata_i),
        .cutoff_en_i(cutoff_en_i), .ext_irq_pin_i(ext_irq_pin_i),
        .run_bit_ch0_o(run0), .run_bit_ch1_o(run1), .stop_select_ch0_o(sel0),
        .stop_select_ch1_o(sel1), .main_counter_o(cnt), .status_o(stat),
        .ext_irq_sync_o(irq_sync), .pwm_out_a_o(pa), .pwm_out_a_oe_n_o(pa_oe_n),
        .pwm_out_b_o(pb), .pwm_out_b_oe_n_o(pb_oe_n));
    pwm_load_model load_a (.sys_clk_i(sys_clk_i), .pin_i(pa), .oe_n_i(pa_oe_n),
        .act_high_i(act_a), .width_o(wa), .period_o(pera));
    pwm_load_model load_b (.sys_clk_i(sys_clk_i), .pin_i(pb), .oe_n_i(pb_oe_n),
        .act_high_i(act_b), .width_o(wb), .period_o(perb));

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic step(input int cycles = 1);
        repeat (cycles) @(posedge sys_clk_i);
        #1;
    endtask
    task automatic wr_start(input logic [3:0] d);
        start_ctrl_wdata_i = d;
        start_ctrl_wr_i = 1'b1;
        step();
        start_ctrl_wr_i = 1'b0;
        // Idle cycle so a following write never lowers and raises a strobe at once
        step();
    endtask
    task automatic wr_greg(input logic [2:0] s, input int v);
        greg_sel_i = s;
        greg_wdata_i = v[15:0];
        greg_wr_i = 1'b1;
        step();
        greg_wr_i = 1'b0;
        step();
    endtask
    task automatic wr_cnt(input logic [15:0] v);
        counter_wdata_i = v;
        counter_wr_i = 1'b1;
        step();
        counter_wr_i = 1'b0;
        step();
    endtask
    task automatic wr_init(input logic [1:0] v);
        init_level_wdata_i = v;
        init_level_wr_i = 1'b1;
        step();
        init_level_wr_i = 1'b0;
        step();
    endtask
    task automatic wr_stat(input logic rd, input logic [4:0] v);
        status_rd_i = rd;
        step();
        status_rd_i = 1'b0;
        status_wdata_i = v;
        status_wr_i = 1'b1;
        step();
        status_wr_i = 1'b0;
    endtask
    // Program one waveform set, run it, and compare widths with the model
    task automatic measure(input int src, input logic [1:0] init);
        int d;
        d = divs[src];
        wr_start(4'h4);
        clk_sel_i = src[2:0];
        m = 6 + $urandom % 10;
        n = 1 + $urandom % (m - 1);
        p = 2 + $urandom % (m - 2);
        q = 1 + $urandom % (p - 1);
        wr_init(init);
        check("init level a", pa, init[0]);
        check("init level b", pb, init[1]);
        act_a = ~init[0];
        act_b = ~init[1];
        wr_cnt(16'h0000);
        wr_greg(`GREG_A0, m);
        wr_greg(`GREG_A1, n);
        wr_greg(`GREG_B0, p);
        wr_greg(`GREG_B1, q);
        wr_start(4'h5);
        step(3 * (m + 1) * d + 20);
        check("period a", pera, (m + 1) * d);
        check("period b", perb, (m + 1) * d);
        check("width a", wa, (m - n) * d);
        check("width b", wb, (p - q) * d);
        check("ch1 unused", run1, 1'b0);
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial begin
        #40000;
        bad_count++;
        print_verdict();
    end

    initial begin
        void'($urandom(32'hd4706bca));
        step(4);
        reset_n_i = 1'b1;
        check("reset run0", run0, 1'b0);
        check("reset counter", cnt, 32'h0);
        check("reset flags", stat, 32'h0);
        check("reset oe", {pa_oe_n, pb_oe_n}, 32'h0);
        for (int s = 0; s < 6; s++) begin
            measure(s, 2'b00);
        end
        measure(0, 2'b11);
        // Software stop keeps levels and count
        wr_start(4'h4);
        check("soft stop run0", run0, 1'b0);
        step();
        pa_h = pa;
        pb_h = pb;
        c_h = cnt;
        step(17);
        check("hold a", pa, pa_h);
        check("hold b", pb, pb_h);
        check("hold cnt", cnt, c_h);
        k = $urandom % 16'hfff0;
        wr_cnt(k[15:0]);
        check("counter load", cnt, k);
        // Clock enable low freezes the count
        wr_start(4'h5);
        check("start run0", run0, 1'b1);
        step(3);
        clk_en_i = 1'b0;
        step();
        c_h = cnt;
        // Prime span, so no period length can wrap back to the same count
        step(17);
        check("frozen cnt", cnt, c_h);
        clk_en_i = 1'b1;
        // Unused source codes give no count ticks
        clk_sel_i = 3'h6;
        step(2);
        c_h = cnt;
        step(17);
        check("no tick source", cnt, c_h);
        clk_sel_i = `SRC_F1;
        // Auto stop at period match
        wr_start(4'h4);
        wr_cnt(16'h0000);
        wr_stat(1'b1, 5'h00);
        wr_start(4'h1);
        check("stop select auto", {sel1, sel0}, 32'h0);
        k = 0;
        while (run0 !== 1'b0 && k < m + 4) begin
            step();
            k++;
        end
        check("auto stop time", k <= m + 2, 1'b1);
        check("auto stop cnt", cnt, 32'h0);
        check("match flag", stat[`FLG_MA0], 1'b1);
        pa_h = pa;
        step(8);
        check("auto hold a", pa, pa_h);
        // Clearing needs a read of one then a write of zero
        wr_stat(1'b0, 5'h00);
        check("unread clear", stat[`FLG_MA0], 1'b1);
        wr_stat(1'b1, 5'h1f);
        check("write one", stat[`FLG_MA0], 1'b1);
        wr_stat(1'b1, 5'h1e);
        check("read clear", stat[`FLG_MA0], 1'b0);
        // Overflow from ffff
        wr_cnt(16'hfffe);
        wr_start(4'h5);
        step(4);
        check("overflow", stat[`FLG_OVF], 1'b1);
        // Buffered period takes over at the next period match
        wr_greg(`GREG_C0, m + 2);
        buf_en_i = 4'h1;
        step(4 * (m + 3) + 20);
        check("buffered period", pera, m + 3);
        buf_en_i = 4'h0;
        // Channel 1 run bit cleared by its match
        wr_start(4'h4);
        wr_cnt(16'h0000);
        wr_start(4'h7);
        check("run1 set", run1, 1'b1);
        check("stop selects", {sel1, sel0}, 32'h1);
        k = 0;
        while (run1 !== 1'b0 && k < m + 4) begin
            step();
            k++;
        end
        check("run1 auto clear", run1, 1'b0);
        check("run0 kept", run0, 1'b1);
        // With its stop select set, channel 1 waits for software
        wr_start(4'hf);
        step(2 * (m + 1));
        check("run1 held", run1, 1'b1);
        check("stop selects set", {sel1, sel0}, 32'h3);
        wr_start(4'h4);
        check("run1 soft stop", run1, 1'b0);
        // Forced cutoff by the external pin
        cutoff_en_i = 1'b1;
        ext_irq_pin_i = 1'b0;
        step(4);
        check("cutoff oe", {pa_oe_n, pb_oe_n}, 32'h3);
        check("pin sync low", irq_sync, 1'b0);
        ext_irq_pin_i = 1'b1;
        step(4);
        check("cutoff release", {pa_oe_n, pb_oe_n}, 32'h0);
        check("pin sync high", irq_sync, 1'b1);
        cutoff_en_i = 1'b0;
        print_verdict();
    end
endmodule
